// ### include/ocs_params.svh
// Offsets, field positions, reset values and counts of the clock select block
`ifndef OCS_PARAMS_SVH
`define OCS_PARAMS_SVH

// ==========================================================================
// Register map (byte addresses)
`define OCS_OFF_STATUS      4'h0
`define OCS_OFF_TRIM        4'h4
`define OCS_OFF_CONFIG      4'h8

// ==========================================================================
// Fields
`define OCS_STAT_REQ_BIT    0
`define OCS_STAT_ENG_BIT    1
`define OCS_CFG_SEL_LSB     0
`define OCS_CFG_OUTEN_BIT   2

// ==========================================================================
// Reset values and source codes
`define OCS_TRIM_RESET      8'h80
`define OCS_SEL_INTERNAL    2'h0
`define OCS_SEL_EXT_CLOCK   2'h1
`define OCS_SEL_EXT_RC      2'h2
`define OCS_SEL_CRYSTAL     2'h3

// ==========================================================================
// Timing and bus response codes
`define OCS_INT_OSC_KHZ     12800
`define OCS_BUS_KHZ         3200
`define OCS_CONFIRM_EDGES   2'h2
`define OCS_RESP_OKAY       2'h0
`define OCS_RESP_SLVERR     2'h2

`endif

// ### include/ocs_pkg.sv
// Types shared by the clock select block
package ocs_pkg;

    typedef enum logic [2:0] {
        OCS_ST_INT,
        OCS_ST_CONFIRM,
        OCS_ST_ALIGN,
        OCS_ST_ENGAGE,
        OCS_ST_EXT
    } ocs_state_t;

    typedef struct packed {
        logic       clock_out_pin_enable;
        logic [1:0] clock_source_select;
    } ocs_cfg_t;

endpackage

// ### rtl/ocs_clock_select.sv
// Oscillator clock source select, internal-to-external switch and AXI4-Lite registers
//
// Functional notes
// [RULE_01] Internal clock nominal 12.8 MHz, bus 3.2 MHz
// [RULE_02] 8-bit trim, larger value longer period
// [RULE_03] Software copies factory trim, never automatic
// [RULE_04] Software may precharge crystal via port pin
// [RULE_05] External selection makes input pin clock input
// [RULE_06] Software waits stabilization before requesting switch
// [RULE_07] Software sets external clock request bit
// [RULE_08] Two external rising edges confirm activity
// [RULE_09] Source switch is glitch free
// [RULE_10] Set engaged flag, then stop internal oscillator
// [RULE_11] Internal oscillator restarts only through reset
// [RULE_12] No clock monitor, no fallback to internal
// [RULE_13] External mode: pin is x4, halved x2
// [RULE_14] External mode: output pin is port I/O
// [RULE_15] Crystal mode: output pin drives inverted amplifier
// [RULE_16] Internal/RC: enable bit puts x4 on pin
// [RULE_17] Oscillator enable input gates selected source
// [RULE_18] x4 clock equals selected source clock
// [RULE_19] x2 clock is half of x4
// [RULE_20] Select codes: 00 int,01 ext,10 RC,11 xtal
// [RULE_21] Reset forces external clock request low
// [RULE_22] Stop mode disables source, x4 and x2
// [RULE_23] Request synchronized before counting confirming edges
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`include "ocs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ocs_clock_select
    import ocs_pkg::*;
#(
    parameter int INT_HALF_BASE = 4
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        clock_input_pin,
    input  wire logic        external_rc_clock,
    input  wire logic        crystal_clock,
    input  wire logic        oscillator_enable_in,
    input  wire logic        stop_mode,
    input  wire logic        port_bit_four_out,
    input  wire logic        port_bit_four_oe_n,
    output logic             clock_output_pin_out,
    output logic             clock_output_pin_oe_n,
    output logic             clock_input_pin_is_clock,
    output logic             quad_rate_clock,
    output logic             double_rate_clock
);

    // ======================================================================
    // Registers
    logic           external_clock_request;
    logic           external_clock_engaged;
    logic [7:0]     internal_clock_trim;
    ocs_cfg_t       cfg;
    ocs_state_t     state;

    logic           wr_go;
    logic           rd_go;
    logic [31:0]    rd_word;
    logic           rd_hit;
    logic           wr_hit;

    assign wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    assign rd_go  = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    assign wr_hit = (s_axi_awaddr == `OCS_OFF_STATUS) || (s_axi_awaddr == `OCS_OFF_TRIM)
                    || (s_axi_awaddr == `OCS_OFF_CONFIG);

    always_comb begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            `OCS_OFF_STATUS: begin
                rd_word[`OCS_STAT_REQ_BIT] = external_clock_request;
                rd_word[`OCS_STAT_ENG_BIT] = external_clock_engaged;
            end
            `OCS_OFF_TRIM:   rd_word[7:0] = internal_clock_trim;
            `OCS_OFF_CONFIG: rd_word[2:0] = cfg;
            default:         rd_hit = 1'b0;
        endcase
    end

    // Write channel: address and data taken together, one pulse of ready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `OCS_RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready  <= wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `OCS_RESP_OKAY : `OCS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `OCS_RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? `OCS_RESP_OKAY : `OCS_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Trim is never loaded from nonvolatile memory here; software copies it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            external_clock_request <= 1'b0; // RULE_21
            internal_clock_trim    <= `OCS_TRIM_RESET; // RULE_03
            cfg                    <= '0;
        end else if (wr_go) begin
            case (s_axi_awaddr)
                `OCS_OFF_STATUS: if (s_axi_wstrb[0]) begin
                    external_clock_request <= s_axi_wdata[`OCS_STAT_REQ_BIT]; // RULE_07
                end
                `OCS_OFF_TRIM: if (s_axi_wstrb[0]) begin
                    internal_clock_trim <= s_axi_wdata[7:0];
                end
                `OCS_OFF_CONFIG: if (s_axi_wstrb[0]) begin
                    cfg <= s_axi_wdata[2:0];
                end
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Internal oscillator model
    logic           int_clk;
    logic [8:0]     int_cnt;
    logic [8:0]     int_half;
    logic           run_en;
    logic           int_run;

    // Half period grows with trim; reset value gives the nominal rate
    assign int_half = 9'(INT_HALF_BASE) + {1'b0, internal_clock_trim}; // RULE_02
    assign run_en   = oscillator_enable_in && !stop_mode; // RULE_17 RULE_22
    // Stopped while run_en is low, else only once engaged is already showing
    assign int_run  = run_en && (state != OCS_ST_EXT); // RULE_10 RULE_11

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_cnt <= 9'h0;
            int_clk <= 1'b0;
        end else if (int_run) begin // RULE_01
            if (int_cnt >= int_half - 9'h1) begin
                int_cnt <= 9'h0;
                int_clk <= !int_clk;
            end else begin
                int_cnt <= int_cnt + 9'h1;
            end
        end else if (state == OCS_ST_EXT) begin
            int_clk <= 1'b0;
        end
    end

    // ======================================================================
    // External source and switch sequence
    logic           ext_src;
    logic           ext_q;
    logic           ext_rise;
    logic           req_s1;
    logic           req_s2;
    logic [1:0]     edge_cnt;

    always_comb begin
        case (cfg.clock_source_select) // RULE_20
            `OCS_SEL_EXT_CLOCK: ext_src = clock_input_pin; // RULE_13
            `OCS_SEL_EXT_RC:    ext_src = external_rc_clock;
            `OCS_SEL_CRYSTAL:   ext_src = crystal_clock;
            default:            ext_src = 1'b0;
        endcase
    end

    assign ext_rise = ext_src && !ext_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_q  <= 1'b0;
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
        end else begin
            ext_q  <= ext_src;
            req_s1 <= external_clock_request; // RULE_23
            req_s2 <= req_s1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= OCS_ST_INT;
            edge_cnt <= 2'h0;
        end else begin
            case (state)
                OCS_ST_INT: begin
                    edge_cnt <= 2'h0;
                    if (req_s2 && cfg.clock_source_select != `OCS_SEL_INTERNAL) begin
                        state <= OCS_ST_CONFIRM;
                    end
                end
                OCS_ST_CONFIRM: begin
                    if (!req_s2) begin
                        state <= OCS_ST_INT;
                    end else if (ext_rise) begin
                        edge_cnt <= edge_cnt + 2'h1;
                        if (edge_cnt + 2'h1 == `OCS_CONFIRM_EDGES) begin // RULE_08
                            state <= OCS_ST_ALIGN;
                        end
                    end
                end
                OCS_ST_ALIGN: begin
                    // Hand over only while both clocks are low: no runt pulse
                    if (!int_clk && !ext_src) begin // RULE_09
                        state <= OCS_ST_ENGAGE;
                    end
                end
                OCS_ST_ENGAGE: state <= OCS_ST_EXT;
                OCS_ST_EXT:    state <= OCS_ST_EXT; // RULE_12
                default:       state <= OCS_ST_INT;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            external_clock_engaged <= 1'b0;
        end else if (state == OCS_ST_ALIGN && !int_clk && !ext_src) begin
            external_clock_engaged <= 1'b1; // RULE_10
        end
    end

    // ======================================================================
    // Output clocks and pins
    logic           src_clk;
    logic           next_quad;
    logic           sel_ext_mode;

    assign sel_ext_mode = external_clock_engaged;
    assign src_clk      = sel_ext_mode ? ext_src : int_clk;
    assign next_quad    = run_en && src_clk; // RULE_18 RULE_22

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            quad_rate_clock   <= 1'b0;
            double_rate_clock <= 1'b0;
        end else begin
            quad_rate_clock <= next_quad;
            if (next_quad && !quad_rate_clock) begin
                double_rate_clock <= !double_rate_clock; // RULE_19
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_output_pin_out     <= 1'b0;
            clock_output_pin_oe_n    <= 1'b1;
            clock_input_pin_is_clock <= 1'b0;
        end else begin
            clock_input_pin_is_clock <= (cfg.clock_source_select != `OCS_SEL_INTERNAL); // RULE_05
            case (cfg.clock_source_select)
                `OCS_SEL_CRYSTAL: begin
                    clock_output_pin_out  <= !clock_input_pin; // RULE_05 RULE_15
                    clock_output_pin_oe_n <= 1'b0;
                end
                `OCS_SEL_EXT_CLOCK: begin
                    clock_output_pin_out  <= port_bit_four_out; // RULE_14
                    clock_output_pin_oe_n <= port_bit_four_oe_n;
                end
                default: begin
                    if (cfg.clock_out_pin_enable) begin
                        clock_output_pin_out  <= next_quad; // RULE_16
                        clock_output_pin_oe_n <= 1'b0;
                    end else begin
                        clock_output_pin_out  <= port_bit_four_out;
                        clock_output_pin_oe_n <= port_bit_four_oe_n;
                    end
                end
            endcase
        end
    end

    // ======================================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_req_reset_low: assert property (disable iff (1'b0) !aresetn |=> !external_clock_request) // RULE_21
        else $error("request not cleared by reset");
    a_two_edges: assert property ($rose(external_clock_engaged) |-> // RULE_08
        $past(state, 2) inside {OCS_ST_CONFIRM, OCS_ST_ALIGN})
        else $error("engaged without confirmation");
    a_confirm_edges: assert property ((state == OCS_ST_CONFIRM ##1 state == OCS_ST_ALIGN) |-> // RULE_08
        $past(ext_rise) && $past(edge_cnt) == 2'h1)
        else $error("confirmation left before second rising edge");
    a_glitch_free: assert property ($rose(external_clock_engaged) |-> // RULE_09
        !$past(int_clk) && !$past(ext_src))
        else $error("switch while a clock was high");
    a_stop_order: assert property (state == OCS_ST_EXT |-> external_clock_engaged) // RULE_10
        else $error("internal oscillator stopped before engaged");
    a_no_fallback: assert property (state == OCS_ST_EXT |=> state == OCS_ST_EXT ##1 !int_clk) // RULE_12
        else $error("left external mode without reset");
    a_stop_gates: assert property (stop_mode |=> !quad_rate_clock) // RULE_22
        else $error("x4 clock running in stop mode");
    a_x2_half: assert property ($rose(quad_rate_clock) |-> // RULE_19
        double_rate_clock != $past(double_rate_clock))
        else $error("x2 clock did not toggle");
    a_xtal_pin: assert property (cfg.clock_source_select == `OCS_SEL_CRYSTAL |=> // RULE_15
        !clock_output_pin_oe_n && clock_output_pin_out == !$past(clock_input_pin))
        else $error("crystal amplifier output wrong");
    a_ext_pin: assert property (cfg.clock_source_select == `OCS_SEL_EXT_CLOCK |=> // RULE_14
        clock_output_pin_oe_n == $past(port_bit_four_oe_n))
        else $error("output pin not port I/O in external mode");
    a_trim_reset: assert property (disable iff (1'b0) !aresetn |=> // RULE_02
        internal_clock_trim == `OCS_TRIM_RESET)
        else $error("trim reset value wrong");

    c_switch_done: cover property ($rose(external_clock_engaged));
    c_abort: cover property (state == OCS_ST_CONFIRM ##1 state == OCS_ST_INT);
    c_clk_out: cover property (cfg.clock_out_pin_enable && !clock_output_pin_oe_n
        && cfg.clock_source_select == `OCS_SEL_INTERNAL);
    c_bad_addr: cover property (s_axi_bvalid && s_axi_bresp == `OCS_RESP_SLVERR);

endmodule

`default_nettype wire

// ### testbench/ocs_far_side_model.sv
// Far-side model: external clock, RC network and crystal sources
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Source clocks
module ocs_far_side_model #(
    parameter int EXT_HALF = 3,
    parameter int RC_HALF  = 5,
    parameter int XT_HALF  = 4
) (
    input  wire logic aclk,
    input  wire logic ext_run,
    output logic      clock_input_pin,
    output logic      external_rc_clock,
    output logic      crystal_clock
);
    logic ext_q = 1'b0;
    logic rc_q  = 1'b0;
    logic xt_q  = 1'b0;
    int   cnt   = 0;

    // A dead component holds its last level, so no edge reaches the block
    always_ff @(posedge aclk) begin
        if (ext_run) begin
            cnt <= cnt + 1;
            if (cnt % EXT_HALF == 0) ext_q <= !ext_q;
            if (cnt % RC_HALF == 0) rc_q <= !rc_q;
            if (cnt % XT_HALF == 0) xt_q <= !xt_q;
        end
    end

    assign clock_input_pin   = ext_q;
    assign external_rc_clock = rc_q;
    assign crystal_clock     = xt_q;
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the oscillator clock select block
`timescale 1ns/1ps
`default_nettype none
`include "ocs_params.svh"

// ==========================================================
// Signals and instances
module tb_top;
    import ocs_pkg::*;
    localparam int HB = 4;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic        clock_input_pin, external_rc_clock, crystal_clock;
    logic        oscillator_enable_in = 1'b1;
    logic        stop_mode = 1'b0;
    logic        port_bit_four_out = 1'b0;
    logic        port_bit_four_oe_n = 1'b1;
    logic        clock_output_pin_out, clock_output_pin_oe_n, clock_input_pin_is_clock;
    logic        quad_rate_clock, double_rate_clock;
    logic        ext_run = 1'b0;
    int          err_total = 0;
    int          check_count = 0;
    logic [31:0] rd;
    logic [1:0]  rr;
    int          half [4] = '{0, 3, 5, 4};

    always #5 aclk = !aclk;

    ocs_clock_select #(.INT_HALF_BASE(HB)) uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clock_input_pin, .external_rc_clock,
        .crystal_clock, .oscillator_enable_in, .stop_mode, .port_bit_four_out,
        .port_bit_four_oe_n, .clock_output_pin_out, .clock_output_pin_oe_n,
        .clock_input_pin_is_clock, .quad_rate_clock, .double_rate_clock
    );

    ocs_far_side_model far (
        .aclk, .ext_run, .clock_input_pin, .external_rc_clock, .crystal_clock
    );

    // ==========================================================
    // Reporting
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic timed_out(input string what);
        err_total++;
        $display("wrong value %s expected answer seen timeout", what);
        tally_and_finish();
    endtask

    // ==========================================================
    // Bus and clock helpers
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        s_axi_bready <= 1'b0;
        if (n >= 100) timed_out("bvalid");
        check("bresp", s_axi_bresp, er);
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n >= 100) timed_out("rvalid");
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        axi_read(a, rd, rr);
        check(what, rd, e);
        check("rresp", rr, er);
    endtask

    // Cycles up to the next rise of the x4 or x2 clock
    task automatic gap(input bit dbl, output int n);
        logic p;
        logic s;
        n = 0;
        p = dbl ? double_rate_clock : quad_rate_clock;
        do begin
            @(posedge aclk);
            n++;
            s = dbl ? double_rate_clock : quad_rate_clock;
            if (!p && s) break;
            p = s;
        end while (n < 2000);
        if (n >= 2000) timed_out("clock edge");
    endtask

    task automatic period_chk(input string what, input bit dbl, input int e);
        int n;
        gap(dbl, n);
        gap(dbl, n);
        check(what, n, e);
    endtask

    task automatic follow(input logic [1:0] sel, input bit en, input bit eng);
        logic sq;
        logic iq;
        sq = 1'b0;
        iq = 1'b0;
        repeat (4) @(posedge aclk);
        for (int i = 0; i < 24; i++) begin
            @(posedge aclk);
            if (eng && i > 0) check("x4 source", quad_rate_clock, sq);
            if (sel == 2'h3) begin
                if (i > 0) check("pin xtal", clock_output_pin_out, !iq);
                check("oe xtal", clock_output_pin_oe_n, 0);
            end else if (sel == 2'h1 || !en) begin
                check("pin port", clock_output_pin_out, port_bit_four_out);
                check("oe port", clock_output_pin_oe_n, port_bit_four_oe_n);
            end else begin
                check("pin x4", clock_output_pin_out, quad_rate_clock);
                check("oe x4", clock_output_pin_oe_n, 0);
            end
            sq = sel == 2'h1 ? clock_input_pin : sel == 2'h2 ? external_rc_clock : crystal_clock;
            iq = clock_input_pin;
        end
    endtask

    task automatic quiet(input bit zero);
        logic q0;
        logic d0;
        repeat (3) @(posedge aclk);
        q0 = quad_rate_clock;
        d0 = double_rate_clock;
        if (zero) check("x4 low", q0, 0);
        repeat (40) begin
            @(posedge aclk);
            check("x4 still", quad_rate_clock, q0);
            check("x2 still", double_rate_clock, d0);
        end
    endtask

    task automatic reset_dut;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // ==========================================================
    // Test sequence
    initial begin
        reset_dut();
        rd_chk("status", `OCS_OFF_STATUS, 32'h0, `OCS_RESP_OKAY);
        rd_chk("trim", `OCS_OFF_TRIM, 32'h80, `OCS_RESP_OKAY);
        rd_chk("config", `OCS_OFF_CONFIG, 32'h0, `OCS_RESP_OKAY);
        rd_chk("unmapped", 4'hc, 32'h0, `OCS_RESP_SLVERR);
        axi_write(4'hc, 32'h1, `OCS_RESP_SLVERR);
        axi_write(`OCS_OFF_STATUS, 32'h2, `OCS_RESP_OKAY);
        rd_chk("engaged read-only", `OCS_OFF_STATUS, 32'h0, `OCS_RESP_OKAY);
        axi_write(`OCS_OFF_TRIM, 32'h3ff, `OCS_RESP_OKAY);
        rd_chk("trim width", `OCS_OFF_TRIM, 32'hff, `OCS_RESP_OKAY);
        $display("test registers done");
        period_chk("x4 trim max", 0, 2 * (HB + 255));
        axi_write(`OCS_OFF_TRIM, 32'h80, `OCS_RESP_OKAY);
        period_chk("x4 trim reset", 0, 2 * (HB + 128));
        axi_write(`OCS_OFF_TRIM, 32'h2, `OCS_RESP_OKAY);
        period_chk("x4 trim 2", 0, 2 * (HB + 2));
        period_chk("x2 trim 2", 1, 4 * (HB + 2));
        axi_write(`OCS_OFF_TRIM, 32'h5, `OCS_RESP_OKAY);
        period_chk("x4 trim 5", 0, 2 * (HB + 5));
        follow(2'h0, 1'b0, 1'b0);
        axi_write(`OCS_OFF_CONFIG, 32'h4, `OCS_RESP_OKAY);
        follow(2'h0, 1'b1, 1'b0);
        $display("test internal clock done");
        stop_mode <= 1'b1;
        quiet(1'b1);
        stop_mode <= 1'b0;
        oscillator_enable_in <= 1'b0;
        quiet(1'b1);
        oscillator_enable_in <= 1'b1;
        axi_write(`OCS_OFF_STATUS, 32'h1, `OCS_RESP_OKAY);
        repeat (60) @(posedge aclk);
        rd_chk("no switch on 00", `OCS_OFF_STATUS, 32'h1, `OCS_RESP_OKAY);
        $display("test stop and enable done");
        port_bit_four_out <= 1'b1;
        port_bit_four_oe_n <= 1'b0;
        for (int s = 1; s < 4; s++) begin
            reset_dut();
            ext_run <= 1'b0;
            axi_write(`OCS_OFF_CONFIG, 32'h4 | s, `OCS_RESP_OKAY);
            // Pin function follows the select one edge after it lands
            @(posedge aclk);
            check("input is clock", clock_input_pin_is_clock, 1);
            follow(s[1:0], 1'b1, 1'b0);
            // Dead source: the switch must not engage without its edges
            axi_write(`OCS_OFF_STATUS, 32'h1, `OCS_RESP_OKAY);
            repeat (100) @(posedge aclk);
            rd_chk("not engaged", `OCS_OFF_STATUS, 32'h1, `OCS_RESP_OKAY);
            ext_run <= 1'b1;
            repeat (40) @(posedge aclk);
            // Hand-over may wait a whole internal half period for both clocks low
            for (int n = 0; n < 200; n++) begin
                axi_read(`OCS_OFF_STATUS, rd, rr);
                if (rd[1] === 1'b1) break;
            end
            if (rd[1] !== 1'b1) timed_out("engaged flag");
            check("status engaged", rd, 32'h3);
            follow(s[1:0], 1'b1, 1'b1);
            period_chk("x4 external", 0, 2 * half[s]);
            period_chk("x2 external", 1, 4 * half[s]);
            ext_run <= 1'b0;
            quiet(1'b0);
            axi_write(`OCS_OFF_STATUS, 32'h0, `OCS_RESP_OKAY);
            rd_chk("stays engaged", `OCS_OFF_STATUS, 32'h2, `OCS_RESP_OKAY);
            $display("test switch select %0d done", s);
        end
        reset_dut();
        rd_chk("status after reset", `OCS_OFF_STATUS, 32'h0, `OCS_RESP_OKAY);
        period_chk("x4 internal again", 0, 2 * (HB + 128));
        $display("test reset return done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
